// *** design/ptd_parity.v ***
`timescale 1ns/1ns
`default_nettype none

// even parity over 32 address/data and 4 command lines, one cycle late
module ptd_parity (
	input wire clk_sys,
	input wire rst_n,
	input wire [31:0] ad,
	input wire [3:0] cbe,
	input wire par_in,
	output reg par_calc_reg,
	output reg par_bad_reg
);

	wire par_now;

	assign par_now = ^{ad, cbe};

	// calc lags data by one cycle; bad compares it with the arriving bit
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			par_calc_reg <= 1'b0;
			par_bad_reg <= 1'b0;
		end else begin
			par_calc_reg <= par_now;
			par_bad_reg <= par_calc_reg ^ par_in;
		end
	end

endmodule // ptd_parity

`default_nettype wire

// *** design/ptd_top.v ***
`timescale 1ns/1ns
`default_nettype none
`include "ptd_map.vh"

module ptd_top #(
	parameter WIN0_BITS = `PTD_WIN0_BITS,
	parameter WIN0_IO = `PTD_WIN0_IO,
	parameter WIN1_BITS = `PTD_WIN1_BITS,
	parameter WIN1_IO = `PTD_WIN1_IO
) (
	input wire clk_sys,
	input wire rst_n,
	input wire [31:0] ad_in,
	output reg [31:0] ad_out_reg,
	output reg ad_oe_n_reg,
	input wire [3:0] cbe_in,
	output reg [3:0] cbe_out_reg,
	output reg cbe_oe_n_reg,
	input wire parity_line_in,
	output reg parity_line_out_reg,
	output reg parity_line_oe_n_reg,
	input wire frame_n,
	input wire irdy_n,
	input wire idsel,
	output reg devsel_n_out_reg,
	output reg devsel_oe_n_reg,
	output reg perr_n_out_reg,
	output reg perr_oe_n_reg,
	input wire [31:0] win0_base,
	input wire [31:0] win1_base,
	input wire mem_space_en,
	input wire io_space_en,
	input wire perr_resp_en,
	input wire parity_err_clr,
	input wire src_drive,
	input wire [31:0] src_ad,
	input wire src_cbe_drive,
	input wire [3:0] src_cbe,
	input wire src_cmd_phase,
	output reg [15:0] pci_cmd_reg,
	output reg [31:0] addr_reg,
	output reg address_latched_flag_reg,
	output reg [3:0] s_cbe_reg,
	output reg hit_win0_reg,
	output reg hit_win1_reg,
	output reg detected_parity_error_bit_reg
);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------

	// compare the upper bits of an address with a window base
	function win_hit;
		input [31:0] a;
		input [31:0] b;
		input integer bits;
		reg [31:0] mask;
		begin
			mask = ~(32'hFFFF_FFFF >> bits);
			win_hit = ((a ^ b) & mask) == 32'h0000_0000;
		end
	endfunction

	// clamp window width to the supported 4..28 range
	function integer win_bits;
		input integer req;
		begin
			if (req < `PTD_WIN_MIN_BITS)
				win_bits = `PTD_WIN_MIN_BITS;
			else if (req > `PTD_WIN_MAX_BITS)
				win_bits = `PTD_WIN_MAX_BITS;
			else
				win_bits = req;
		end
	endfunction

	localparam integer W0 = win_bits(WIN0_BITS);
	localparam integer W1 = win_bits(WIN1_BITS);

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------

	reg [39:0] pin_meta_reg;
	reg [39:0] pin_sync_reg;
	reg addr_d_reg;
	reg frame_prev_reg;
	reg [3:0] cmd_q_reg;
	reg claimed_reg;
	reg rx_phase_reg;
	reg rx_phase_d_reg;
	reg tx_d_reg;
	wire [31:0] ad_s;
	wire [3:0] cbe_s;
	wire par_s;
	wire frame_s_n;
	wire irdy_s_n;
	wire idsel_s;
	wire addr_phase;
	wire is_mem;
	wire is_io;
	wire is_cfg;
	wire is_write;
	wire hit0;
	wire hit1;
	wire hitc;
	wire par_bad;
	wire perr_now;

	// first stage feeds only the second; bus pins are asynchronous here
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pin_meta_reg <= {40{1'b1}};
			pin_sync_reg <= {40{1'b1}};
		end else begin
			pin_meta_reg <= {idsel, irdy_n, frame_n, parity_line_in,
				cbe_in, ad_in};
			pin_sync_reg <= pin_meta_reg;
		end
	end

	assign ad_s = pin_sync_reg[31:0];
	assign cbe_s = pin_sync_reg[35:32];
	assign par_s = pin_sync_reg[36];
	assign frame_s_n = pin_sync_reg[37];
	assign irdy_s_n = pin_sync_reg[38];
	assign idsel_s = pin_sync_reg[39];

	// ----------------------------------------------------------------
	// address phase and command decode
	// ----------------------------------------------------------------

	// falling edge of frame marks the address phase
	assign addr_phase = frame_prev_reg & ~frame_s_n;

	// write-invalidate counts as plain memory space access
	assign is_mem = (cbe_s == `PTD_CMD_MEM_RD) ||
		(cbe_s == `PTD_CMD_MEM_WR) || (cbe_s == `PTD_CMD_MEM_RDM) ||
		(cbe_s == `PTD_CMD_MEM_RDL) ||
		(cbe_s == `PTD_CMD_MEM_WRI);
	assign is_io = (cbe_s == `PTD_CMD_IO_RD) ||
		(cbe_s == `PTD_CMD_IO_WR);
	assign is_cfg = ((cbe_s == `PTD_CMD_CFG_RD) ||
		(cbe_s == `PTD_CMD_CFG_WR)) && idsel_s &&
		(ad_s[1:0] == `PTD_CFG_TYPE0);

	// window hit needs the space bit to agree with the command
	assign hit0 = win_hit(ad_s, win0_base, W0) &&
		(WIN0_IO ? (is_io && io_space_en) :
		(is_mem && mem_space_en));
	assign hit1 = win_hit(ad_s, win1_base, W1) &&
		(WIN1_IO ? (is_io && io_space_en) :
		(is_mem && mem_space_en));
	assign hitc = is_cfg;

	// write commands: bit 0 of the code, config and i/o alike
	assign is_write = cmd_q_reg[0];

	// latch address and one-hot command, hold until the next address phase
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			frame_prev_reg <= 1'b1;
			pci_cmd_reg <= `PTD_CMD_RST;
			cmd_q_reg <= 4'h0;
			addr_reg <= `PTD_ADDR_RST;
			address_latched_flag_reg <= 1'b0;
			claimed_reg <= 1'b0;
			hit_win0_reg <= 1'b0;
			hit_win1_reg <= 1'b0;
			devsel_n_out_reg <= 1'b1;
			devsel_oe_n_reg <= 1'b1;
			s_cbe_reg <= 4'h0;
		end else begin
			frame_prev_reg <= frame_s_n;
			address_latched_flag_reg <= addr_phase;
			if (addr_phase) begin
				pci_cmd_reg <= 16'h0001 << cbe_s;
				cmd_q_reg <= cbe_s;
				addr_reg <= ad_s;
				hit_win0_reg <= hit0;
				hit_win1_reg <= hit1;
				claimed_reg <= hit0 | hit1 | hitc;
				devsel_n_out_reg <= ~(hit0 | hit1 | hitc);
				devsel_oe_n_reg <= ~(hit0 | hit1 | hitc);
			end else if (frame_s_n && irdy_s_n) begin
				// bus idle: release select, command stays readable
				claimed_reg <= 1'b0;
				hit_win0_reg <= 1'b0;
				hit_win1_reg <= 1'b0;
				devsel_n_out_reg <= 1'b1;
				devsel_oe_n_reg <= 1'b1;
			end
			if (!addr_phase)
				s_cbe_reg <= cbe_s;
		end
	end

	// ----------------------------------------------------------------
	// drive path and parity
	// ----------------------------------------------------------------

	// initiator never puts write-invalidate out; it becomes memory write
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ad_out_reg <= 32'h0000_0000;
			ad_oe_n_reg <= 1'b1;
			cbe_out_reg <= 4'h0;
			cbe_oe_n_reg <= 1'b1;
			tx_d_reg <= 1'b0;
		end else begin
			ad_out_reg <= src_ad;
			ad_oe_n_reg <= ~src_drive;
			if (src_cmd_phase && (src_cbe == `PTD_CMD_MEM_WRI))
				cbe_out_reg <= `PTD_CMD_MEM_WR;
			else
				cbe_out_reg <= src_cbe;
			cbe_oe_n_reg <= ~src_cbe_drive;
			tx_d_reg <= src_drive;
		end
	end

	// parity of what is on the bus, own drive included, one cycle late
	ptd_parity u_par (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.ad(src_drive ? src_ad : ad_s),
		.cbe(src_cbe_drive ? src_cbe : cbe_s),
		.par_in(par_s),
		.par_calc_reg(),
		.par_bad_reg(par_bad)
	);

	// receive data phase of a claimed write, or any address phase
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rx_phase_reg <= 1'b0;
			rx_phase_d_reg <= 1'b0;
			addr_d_reg <= 1'b0;
		end else begin
			rx_phase_reg <= addr_phase | (claimed_reg && is_write &&
				!irdy_s_n && !src_drive);
			rx_phase_d_reg <= rx_phase_reg;
			addr_d_reg <= address_latched_flag_reg;
		end
	end

	// verdict lags its slot by one; delayed flags keep them paired
	assign perr_now = par_bad && rx_phase_d_reg && !addr_d_reg;

	// parity out one cycle after data; error line three cycles after received data
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			parity_line_out_reg <= 1'b0;
			parity_line_oe_n_reg <= 1'b1;
			perr_n_out_reg <= 1'b1;
			perr_oe_n_reg <= 1'b1;
			detected_parity_error_bit_reg <= 1'b0;
		end else begin
			parity_line_out_reg <= ^{ad_out_reg, !cbe_oe_n_reg ?
				cbe_out_reg : cbe_s};
			parity_line_oe_n_reg <= ~tx_d_reg;
			perr_n_out_reg <= ~(perr_now && perr_resp_en);
			perr_oe_n_reg <= ~(rx_phase_d_reg && !addr_d_reg &&
				perr_resp_en);
			// a new error wins over a clear in the same cycle
			if (par_bad && rx_phase_d_reg)
				detected_parity_error_bit_reg <= 1'b1;
			else if (parity_err_clr)
				detected_parity_error_bit_reg <= 1'b0;
		end
	end

endmodule // ptd_top

`default_nettype wire

// *** pkg/ptd_map.vh ***
`ifndef PTD_MAP_VH
`define PTD_MAP_VH

// bus command codes seen on the command/byte-enable lines
`define PTD_CMD_IO_RD 4'h2
`define PTD_CMD_IO_WR 4'h3
`define PTD_CMD_MEM_RD 4'h6
`define PTD_CMD_MEM_WR 4'h7
`define PTD_CMD_CFG_RD 4'hA
`define PTD_CMD_CFG_WR 4'hB
`define PTD_CMD_MEM_RDM 4'hC
`define PTD_CMD_MEM_RDL 4'hE
`define PTD_CMD_MEM_WRI 4'hF

// window defaults: bits compared and space (1 = i/o)
`define PTD_WIN0_BITS 8
`define PTD_WIN0_IO 1'b0
`define PTD_WIN1_BITS 28
`define PTD_WIN1_IO 1'b1
`define PTD_WIN_MIN_BITS 4
`define PTD_WIN_MAX_BITS 28

// type 0 configuration: address bits 1:0 are zero
`define PTD_CFG_TYPE0 2'h0

// reset values
`define PTD_CMD_RST 16'h0000
`define PTD_ADDR_RST 32'h0000_0000

`endif

// *** verif/ptd_chk.sv ***
`timescale 1ns/1ns
`default_nettype none
// ----------------
// port checker
// ----------------
module ptd_chk (
	input wire clk_sys,
	input wire rst_n,
	input wire [3:0] cbe_in,
	input wire frame_n,
	input wire src_drive,
	input wire [31:0] src_ad,
	input wire src_cbe_drive,
	input wire [3:0] src_cbe,
	input wire src_cmd_phase,
	input wire parity_err_clr,
	input wire [31:0] ad_out_reg,
	input wire ad_oe_n_reg,
	input wire [3:0] cbe_out_reg,
	input wire cbe_oe_n_reg,
	input wire parity_line_out_reg,
	input wire parity_line_oe_n_reg,
	input wire devsel_n_out_reg,
	input wire perr_n_out_reg,
	input wire [15:0] pci_cmd_reg,
	input wire address_latched_flag_reg,
	input wire hit_win0_reg,
	input wire hit_win1_reg,
	input wire detected_parity_error_bit_reg
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	// two sync flops then one decode stage
	sequence s_start; $fell(frame_n); endsequence
	sequence s_ans; ##3 address_latched_flag_reg; endsequence
	property p_lat; s_start |-> s_ans; endproperty
	a_lat: assert property (p_lat) else $error("late latch");
	property p_cmd; address_latched_flag_reg |->
		pci_cmd_reg == (16'h1 << $past(cbe_in, 3)); endproperty
	a_cmd: assert property (p_cmd) else $error("bad command");
	property p_hold; !address_latched_flag_reg |-> $stable(pci_cmd_reg);
	endproperty
	a_hold: assert property (p_hold) else $error("command moved");
	// memory codes select window 0, i/o codes window 1
	property p_mem; !devsel_n_out_reg && (pci_cmd_reg & 16'hD0C0) != 16'h0
		|-> hit_win0_reg; endproperty
	a_mem: assert property (p_mem) else $error("mem select");
	property p_io; !devsel_n_out_reg && (pci_cmd_reg & 16'h000C) != 16'h0
		|-> hit_win1_reg; endproperty
	a_io: assert property (p_io) else $error("io select");
	property p_tx; src_drive |=> !ad_oe_n_reg && ad_out_reg == $past(src_ad);
	endproperty
	a_tx: assert property (p_tx) else $error("drive");
	property p_par; !ad_oe_n_reg && !cbe_oe_n_reg |=>
		!parity_line_oe_n_reg &&
		parity_line_out_reg == ^{$past(ad_out_reg), $past(cbe_out_reg)};
	endproperty
	a_par: assert property (p_par) else $error("parity out");
	property p_mwi; src_cbe_drive && src_cmd_phase && src_cbe == 4'hF
		|=> cbe_out_reg == 4'h7; endproperty
	a_mwi: assert property (p_mwi) else $error("mwi issued");
	property p_perr; !perr_n_out_reg |-> detected_parity_error_bit_reg;
	endproperty
	a_perr: assert property (p_perr) else $error("perr alone");
	property p_stick; detected_parity_error_bit_reg && !parity_err_clr
		|=> detected_parity_error_bit_reg; endproperty
	a_stick: assert property (p_stick) else $error("status lost");
endmodule // ptd_chk
bind ptd_top ptd_chk u_chk (
	.clk_sys(clk_sys),
	.rst_n(rst_n),
	.cbe_in(cbe_in),
	.frame_n(frame_n),
	.src_drive(src_drive),
	.src_ad(src_ad),
	.src_cbe_drive(src_cbe_drive),
	.src_cbe(src_cbe),
	.src_cmd_phase(src_cmd_phase),
	.parity_err_clr(parity_err_clr),
	.ad_out_reg(ad_out_reg),
	.ad_oe_n_reg(ad_oe_n_reg),
	.cbe_out_reg(cbe_out_reg),
	.cbe_oe_n_reg(cbe_oe_n_reg),
	.parity_line_out_reg(parity_line_out_reg),
	.parity_line_oe_n_reg(parity_line_oe_n_reg),
	.devsel_n_out_reg(devsel_n_out_reg),
	.perr_n_out_reg(perr_n_out_reg),
	.pci_cmd_reg(pci_cmd_reg),
	.address_latched_flag_reg(address_latched_flag_reg),
	.hit_win0_reg(hit_win0_reg),
	.hit_win1_reg(hit_win1_reg),
	.detected_parity_error_bit_reg(detected_parity_error_bit_reg)
);
`default_nettype wire

// *** verif/ptd_init_model.sv ***
`timescale 1ns/1ns
`default_nettype none
// ----------------
// bus initiator
// ----------------
module ptd_init_model (
	input wire clk_sys,
	output logic frame_n,
	output logic irdy_n,
	output logic idsel,
	output logic [31:0] ad_in,
	output logic [3:0] cbe_in,
	output logic parity_line_in
);
	// idle bus before the first transfer
	initial begin
		frame_n = 1'b1;
		irdy_n = 1'b1;
		idsel = 1'b0;
		ad_in = 32'h0000_0000;
		cbe_in = 4'h0;
		parity_line_in = 1'b0;
	end
	// one data phase; released lines show inverted values, not old ones
	task xfer(input logic [3:0] c, input logic [31:0] a, input logic s,
		input logic bad);
		@(posedge clk_sys);
		frame_n <= 1'b0;
		idsel <= s;
		ad_in <= a;
		cbe_in <= c;
		@(posedge clk_sys);
		frame_n <= 1'b1;
		irdy_n <= 1'b0;
		ad_in <= ~a;
		cbe_in <= 4'h0;
		parity_line_in <= ^{a, c};
		@(posedge clk_sys);
		irdy_n <= 1'b1;
		idsel <= 1'b0;
		ad_in <= a;
		cbe_in <= 4'hF;
		parity_line_in <= ^a ^ bad; // bad data parity only on request
		@(posedge clk_sys);
		parity_line_in <= ~parity_line_in;
	endtask
endmodule // ptd_init_model
`default_nettype wire

// *** verif/ptd_top_tb.sv ***
`timescale 1ns/1ns
`default_nettype none
// ----------------
// bench
// ----------------
module ptd_top_tb;
	localparam logic [31:0] B0 = 32'h5A00_0000;
	localparam logic [31:0] B1 = 32'h0000_C3D0;
	logic clk_sys, rst_n, frame_n, irdy_n, idsel, parity_line_in;
	logic mem_space_en, io_space_en, perr_resp_en, parity_err_clr;
	logic src_drive, src_cbe_drive, src_cmd_phase;
	logic [31:0] ad_in, win0_base, win1_base, src_ad, ad_out_reg, addr_reg;
	logic [3:0] cbe_in, src_cbe, cbe_out_reg, s_cbe_reg;
	logic [15:0] pci_cmd_reg;
	logic ad_oe_n_reg, cbe_oe_n_reg, parity_line_out_reg;
	logic parity_line_oe_n_reg, devsel_n_out_reg, devsel_oe_n_reg;
	logic perr_n_out_reg, perr_oe_n_reg, address_latched_flag_reg;
	logic hit_win0_reg, hit_win1_reg, detected_parity_error_bit_reg;
	int err_total = 0;
	int comparisons = 0;
	ptd_top uut (.*);
	ptd_init_model ini (.*);
	task cmp(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: %h not %h", $time, got, exp);
		end
	endtask
	task conclude;
		$display("mismatches %0d of %0d", err_total, comparisons);
		if (err_total == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// one transfer; checks the answer at the latch pulse
	task xa(input logic [3:0] c, input logic [31:0] a, input logic s,
		input logic bad, input logic hit);
		int n;
		n = 0;
		fork
			ini.xfer(c, a, s, bad);
			do @(negedge clk_sys);
			while (address_latched_flag_reg !== 1'b1 && ++n < 8);
		join
		cmp(pci_cmd_reg, 32'h1 << c);
		cmp(addr_reg, a);
		cmp(devsel_n_out_reg, !hit);
		cmp(devsel_oe_n_reg, !hit);
	endtask
	task s_decode;
		logic [3:0] c [9] = '{2, 3, 6, 7, 4'hA, 4'hB, 4'hC, 4'hE, 4'hF};
		foreach (c[i])
			xa(c[i], c[i][2] ? B0 | 32'h0012_3450 :
				c[i][3] ? 32'h0000_0100 : B1 | 32'h5,
				c[i][3] & !c[i][2], 1'b0, 1'b1);
	endtask
	// window edges and refusals
	task s_miss;
		xa(4'h6, B0 ^ 32'h0100_0000, 1'b0, 1'b0, 1'b0);
		xa(4'h6, B0 | 32'h00FF_FFF0, 1'b0, 1'b0, 1'b1);
		xa(4'h2, B1 ^ 32'h10, 1'b0, 1'b0, 1'b0);
		xa(4'h3, B1 | 32'hF, 1'b0, 1'b0, 1'b1);
		xa(4'h2, B0, 1'b0, 1'b0, 1'b0);
		xa(4'hA, 32'h0000_0100, 1'b0, 1'b0, 1'b0);
		@(posedge clk_sys);
		mem_space_en <= 1'b0;
		xa(4'h7, B0, 1'b0, 1'b0, 1'b0);
		@(posedge clk_sys);
		mem_space_en <= 1'b1;
	endtask
	// bad write data parity, then clear
	task s_rx;
		int n;
		cmp(detected_parity_error_bit_reg, 0);
		xa(4'h7, B0 | 32'h40, 1'b0, 1'b1, 1'b1);
		n = 0;
		do @(negedge clk_sys);
		while (perr_n_out_reg !== 1'b0 && ++n < 8);
		cmp(perr_n_out_reg, 0);
		cmp(perr_oe_n_reg, 0);
		cmp(detected_parity_error_bit_reg, 1);
		repeat (4) @(posedge clk_sys);
		parity_err_clr <= 1'b1;
		@(posedge clk_sys);
		parity_err_clr <= 1'b0;
		@(negedge clk_sys);
		cmp(detected_parity_error_bit_reg, 0);
	endtask
	// initiator drive with a write-invalidate command
	task s_tx;
		@(posedge clk_sys);
		{src_drive, src_cbe_drive, src_cmd_phase} <= 3'h7;
		src_ad <= 32'h8000_0001;
		src_cbe <= 4'hF;
		@(posedge clk_sys);
		{src_drive, src_cbe_drive, src_cmd_phase} <= 3'h0;
		@(negedge clk_sys);
		cmp(ad_out_reg, 32'h8000_0001);
		cmp(cbe_out_reg, 4'h7);
		cmp(cbe_oe_n_reg, 0);
		@(negedge clk_sys);
		cmp(parity_line_oe_n_reg, 0);
		cmp(parity_line_out_reg, ^{32'h8000_0001, 4'h7});
	endtask
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	// watchdog well past the hundred or so cycles of the run
	initial begin
		#20000;
		err_total++;
		conclude;
	end
	initial begin
		{rst_n, parity_err_clr, src_drive, src_cbe_drive} = 4'h0;
		{src_cmd_phase, src_ad, src_cbe} = 37'h0;
		{mem_space_en, io_space_en, perr_resp_en} = 3'h7;
		win0_base = B0;
		win1_base = B1;
		repeat (12) @(posedge clk_sys);
		rst_n <= 1'b1;
		@(negedge clk_sys);
		cmp(devsel_n_out_reg, 1);
		s_decode;
		s_miss;
		s_rx;
		s_tx;
		conclude;
	end
endmodule // ptd_top_tb
`default_nettype wire
